// ### verilog/msd_defines.svh
// constants for the memory space decoder: limits, field positions, bus slot timing
// assumes one i_clk period equals one oscillator period
`ifndef MSD_DEFINES_SVH
`define MSD_DEFINES_SVH

// program space
`define MSD_ROM_TOP          16'h3fff
`define MSD_ROM_AW           14
// internal data space
`define MSD_RAM_DEPTH        256
`define MSD_SFR_BASE         8'h80
`define MSD_BIT_BASE         8'h20
`define MSD_AUX_TOP          16'h00ff
`define MSD_BIT_IDX_LSB      0
`define MSD_BIT_BYTE_LSB     3
// external bus slot: six oscillator periods, phases 0 to 5
`define MSD_SLOT_LAST        3'h5
`define MSD_ALE_LAST         3'h1
`define MSD_STROBE_FIRST     3'h2
`define MSD_STROBE_LAST      3'h4
// values
`define MSD_BLOCKED_DATA     8'h00
`define MSD_STROBE_IDLE      1'h1

`endif

// ### verilog/msd_pkg.sv
// types shared by the memory space decoder files
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package msd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ROM, ST_SFR, ST_SFR_BIT, ST_WAIT, ST_FETCH, ST_XADDR, ST_XDATA
  } msd_state_t;

  typedef enum logic [1:0] {
    KIND_FETCH, KIND_CODE, KIND_XMOVE, KIND_INT
  } msd_kind_t;

  typedef enum logic [2:0] {
    MODE_DIRECT, MODE_INDIRECT, MODE_REG, MODE_BIT, MODE_STACK
  } msd_int_mode_t;
endpackage : msd_pkg

`default_nettype wire

// ### verilog/msd_ram.sv
// 256 x 8 flip-flop ram, two combinational read ports, one clocked write port
// assumes a synchronous active-high reset that clears the contents
`include "msd_defines.svh"
`default_nettype none

module msd_ram (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_we,
  input  wire logic [7:0] i_waddr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] i_raddr_a,
  input  wire logic [7:0] i_raddr_b,
  output logic      [7:0] o_rdata_a,
  output logic      [7:0] o_rdata_b
);
  typedef struct packed {
    logic [`MSD_RAM_DEPTH-1:0][7:0] mem;
  } msd_ram_state_t;

  msd_ram_state_t q;
  msd_ram_state_t d;

  assign o_rdata_a = q.mem[i_raddr_a];
  assign o_rdata_b = q.mem[i_raddr_b];

  always_comb begin
    d = q;
    if (i_we) begin
      d.mem[i_waddr] = i_wdata;
    end
    if (i_sys_rst) begin
      d = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    q <= d;
  end
endmodule : msd_ram

`default_nettype wire

// ### verilog/msd_decoder.sv
// memory space decoder: program fetch steering, code read guard, main/aux ram,
// special register forwarding and the multiplexed external bus engine
// assumes a core that holds each request until its ack and one clock per osc period
//
// Overview of operation
// - latched high: low 16k from rom, rest external
// - latched low: all fetches external, pin ignored after
// - security bit blocks internal code readout
// - code read from external code never returns rom
// - main ram low half direct+indirect, upper indirect
// - direct 128..255 goes to special registers only
// - aux ram via external move, pointer or data pointer
// - aux ram access touches no port pins
// - four eight-byte banks at 0..31
// - register operands use active bank only
// - bytes 32..47 hold 128 addressable bits
// - stack pointer may address all main ram
// - data above 255 via data pointer bus cycle
// - bank pointers never reach external data space
// - lowest 256 data bytes served by aux ram
// - port 0 carries multiplexed low address/data
// - port 2 drives high address byte
// - active-low write and read strobes on port 3
// - ale every six periods, skipped on data access
`include "msd_defines.svh"
`default_nettype none

module msd_decoder (
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic                  i_external_fetch_select,
  input  wire logic                  i_security_bit,
  input  wire logic                  i_fetch_req,
  input  wire logic [15:0]           i_fetch_addr,
  output logic                       o_fetch_ack,
  input  wire logic                  i_code_read_req,
  input  wire logic [15:0]           i_code_read_addr,
  input  wire logic                  i_code_read_from_ext,
  output logic                       o_code_ack,
  input  wire logic                  i_xmove_req,
  input  wire logic                  i_xmove_we,
  input  wire logic                  i_xmove_use_pointer16,
  input  wire logic [15:0]           i_sixteen_bit_pointer,
  output logic                       o_xmove_ack,
  input  wire logic                  i_int_req,
  input  wire logic                  i_int_we,
  input  wire msd_pkg::msd_int_mode_t i_int_mode,
  input  wire logic [7:0]            i_int_addr,
  input  wire logic [2:0]            i_reg_sel,
  input  wire logic                  i_ptr_sel,
  input  wire logic [1:0]            i_bank_sel,
  input  wire logic [7:0]            i_stack_ptr,
  input  wire logic                  i_bit_value,
  output logic                       o_int_ack,
  input  wire logic [7:0]            i_wdata,
  output logic      [7:0]            o_rdata,
  output logic                       o_rom_en,
  output logic      [`MSD_ROM_AW-1:0] o_rom_addr,
  input  wire logic [7:0]            i_rom_data,
  output logic                       o_sfr_req,
  output logic                       o_sfr_we,
  output logic      [7:0]            o_sfr_addr,
  output logic      [7:0]            o_sfr_wdata,
  input  wire logic [7:0]            i_sfr_rdata,
  output logic      [7:0]            o_low_addr_data_out,
  output logic                       o_low_addr_data_oe,
  input  wire logic [7:0]            i_low_addr_data_in,
  output logic      [7:0]            o_high_addr_byte,
  output logic                       o_bus_own,
  output logic                       o_ale,
  output logic                       o_prog_store_en_n,
  output logic                       o_port3_bit6_pin_n,
  output logic                       o_port3_bit7_pin_n
);
  typedef struct packed {
    msd_pkg::msd_state_t   st;
    msd_pkg::msd_kind_t    kind;
    logic [2:0]            ph;
    logic                  fetch_sel;
    logic [15:0]           addr;
    logic [7:0]            wdata;
    logic                  we;
    logic                  is_bit;
    logic [2:0]            bitidx;
    logic                  bitval;
    logic [7:0]            rdata;
    logic                  fetch_ack;
    logic                  code_ack;
    logic                  xmove_ack;
    logic                  int_ack;
    logic                  rom_en;
    logic [`MSD_ROM_AW-1:0] rom_addr;
    logic                  sfr_req;
    logic                  sfr_we;
    logic [7:0]            sfr_addr;
    logic [7:0]            sfr_wdata;
    logic [7:0]            p0_out;
    logic                  p0_oe;
    logic [7:0]            p2;
    logic                  bus_own;
    logic                  ale;
    logic                  psen_n;
    logic                  wr_n;
    logic                  rd_n;
  } msd_dec_state_t;

  msd_dec_state_t q;
  msd_dec_state_t d;

  logic [2:0] reg_idx;
  logic [7:0] a_addr;
  logic [7:0] b_addr;
  logic [7:0] bit_byte;
  logic [7:0] main_a_rdata;
  logic [7:0] main_b_rdata;
  logic [7:0] aux_rdata;
  logic [7:0] x_addr;
  logic       fetch_in_rom;
  logic       code_in_rom;
  logic       sfr_hit;
  logic       ack_busy;
  logic       take;
  logic       m_we;
  logic [7:0] m_wdata;
  logic       x_we;
  logic       done;
  logic [7:0] done_data;
  logic [7:0] bit_merge;
  logic [7:0] sfr_merge;

  ////////////////////////////////////////////////////////////////////////////
  // address formation

  // pointer or register operand inside the active bank
  assign reg_idx  = (!i_xmove_req && i_int_mode == msd_pkg::MODE_REG) ?
                    i_reg_sel : {2'h0, i_ptr_sel};
  assign a_addr   = {3'h0, i_bank_sel, reg_idx};
  assign bit_byte = `MSD_BIT_BASE + {4'h0, i_int_addr[6:`MSD_BIT_BYTE_LSB]};
  assign b_addr   = (i_int_mode == msd_pkg::MODE_DIRECT)   ? i_int_addr :
                    (i_int_mode == msd_pkg::MODE_INDIRECT) ? main_a_rdata :
                    (i_int_mode == msd_pkg::MODE_BIT)      ? bit_byte :
                    (i_int_mode == msd_pkg::MODE_STACK)    ? i_stack_ptr :
                    a_addr;
  assign x_addr   = i_xmove_use_pointer16 ? i_sixteen_bit_pointer[7:0] :
                    main_a_rdata;
  assign fetch_in_rom = q.fetch_sel && (i_fetch_addr <= `MSD_ROM_TOP);
  assign code_in_rom  = q.fetch_sel && (i_code_read_addr <= `MSD_ROM_TOP);
  assign sfr_hit  = (i_int_mode == msd_pkg::MODE_DIRECT ||
                     i_int_mode == msd_pkg::MODE_BIT) &&
                    (i_int_addr >= `MSD_SFR_BASE);
  assign ack_busy = q.fetch_ack || q.code_ack || q.xmove_ack || q.int_ack;
  assign take     = (q.st == msd_pkg::ST_IDLE) && !ack_busy;

  msd_ram u_main_ram (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_we      (m_we),
    .i_waddr   (b_addr),
    .i_wdata   (m_wdata),
    .i_raddr_a (a_addr),
    .i_raddr_b (b_addr),
    .o_rdata_a (main_a_rdata),
    .o_rdata_b (main_b_rdata)
  );

  msd_ram u_aux_ram (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_we      (x_we),
    .i_waddr   (x_addr),
    .i_wdata   (i_wdata),
    .i_raddr_a (x_addr),
    .i_raddr_b (8'h00),
    .o_rdata_a (aux_rdata),
    .o_rdata_b ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d           = q;
    d.fetch_ack = 1'h0;
    d.code_ack  = 1'h0;
    d.xmove_ack = 1'h0;
    d.int_ack   = 1'h0;
    d.sfr_req   = 1'h0;
    d.rom_en    = 1'h0;
    m_we        = 1'h0;
    m_wdata     = i_wdata;
    x_we        = 1'h0;
    done        = 1'h0;
    done_data   = q.rdata;
    bit_merge   = main_b_rdata;
    bit_merge[i_int_addr[2:`MSD_BIT_IDX_LSB]] = i_bit_value;
    sfr_merge   = i_sfr_rdata;
    sfr_merge[q.bitidx] = q.bitval;
    d.ph        = (q.ph == `MSD_SLOT_LAST) ? 3'h0 : q.ph + 3'h1;
    unique case (q.st)
      msd_pkg::ST_IDLE: begin
        if (take && i_fetch_req) begin
          d.kind     = msd_pkg::KIND_FETCH;
          d.addr     = i_fetch_addr;
          d.rom_addr = i_fetch_addr[`MSD_ROM_AW-1:0];
          if (fetch_in_rom) begin
            d.rom_en = 1'h1;
            d.st     = msd_pkg::ST_ROM;
          end else begin
            d.st     = msd_pkg::ST_WAIT;
          end
        end else if (take && i_code_read_req) begin
          d.kind     = msd_pkg::KIND_CODE;
          d.addr     = i_code_read_addr;
          d.rom_addr = i_code_read_addr[`MSD_ROM_AW-1:0];
          if (code_in_rom && i_code_read_from_ext) begin
            d.st = msd_pkg::ST_WAIT;
          end else if (code_in_rom && i_security_bit) begin
            done      = 1'h1;
            done_data = `MSD_BLOCKED_DATA;
          end else if (code_in_rom) begin
            d.rom_en = 1'h1;
            d.st     = msd_pkg::ST_ROM;
          end else begin
            d.st = msd_pkg::ST_WAIT;
          end
        end else if (take && i_xmove_req) begin
          d.kind  = msd_pkg::KIND_XMOVE;
          d.we    = i_xmove_we;
          d.wdata = i_wdata;
          d.addr  = i_xmove_use_pointer16 ? i_sixteen_bit_pointer : {8'h00, main_a_rdata};
          if (i_xmove_use_pointer16 && i_sixteen_bit_pointer > `MSD_AUX_TOP) begin
            d.st = msd_pkg::ST_WAIT;
          end else begin
            x_we      = i_xmove_we;
            done      = 1'h1;
            done_data = aux_rdata;
          end
        end else if (take && i_int_req) begin
          d.kind   = msd_pkg::KIND_INT;
          d.we     = i_int_we;
          d.is_bit = (i_int_mode == msd_pkg::MODE_BIT);
          d.bitidx = i_int_addr[2:`MSD_BIT_IDX_LSB];
          d.bitval = i_bit_value;
          if (sfr_hit) begin
            d.sfr_req   = 1'h1;
            d.sfr_addr  = d.is_bit ? {i_int_addr[7:`MSD_BIT_BYTE_LSB], 3'h0} : i_int_addr;
            d.sfr_we    = i_int_we && !d.is_bit;
            d.sfr_wdata = i_wdata;
            d.st        = (d.is_bit && i_int_we) ? msd_pkg::ST_SFR_BIT : msd_pkg::ST_SFR;
          end else begin
            m_we      = i_int_we;
            done      = 1'h1;
            if (d.is_bit) begin
              m_wdata   = bit_merge;
              done_data = {7'h00, main_b_rdata[i_int_addr[2:`MSD_BIT_IDX_LSB]]};
            end else begin
              done_data = main_b_rdata;
            end
          end
        end
      end
      msd_pkg::ST_ROM: begin
        done      = 1'h1;
        done_data = i_rom_data;
        d.st      = msd_pkg::ST_IDLE;
      end
      msd_pkg::ST_SFR: begin
        done      = 1'h1;
        done_data = q.is_bit ? {7'h00, i_sfr_rdata[q.bitidx]} : i_sfr_rdata;
        d.st      = msd_pkg::ST_IDLE;
      end
      msd_pkg::ST_SFR_BIT: begin
        // read-modify-write of the byte holding the bit
        d.sfr_req   = 1'h1;
        d.sfr_we    = 1'h1;
        d.sfr_wdata = sfr_merge;
        d.st        = msd_pkg::ST_SFR;
      end
      msd_pkg::ST_WAIT: begin
        // bus cycles start on a slot boundary
        if (q.ph == `MSD_SLOT_LAST) begin
          d.st = (q.kind == msd_pkg::KIND_XMOVE) ? msd_pkg::ST_XADDR : msd_pkg::ST_FETCH;
        end
      end
      msd_pkg::ST_FETCH: begin
        if (q.ph == `MSD_SLOT_LAST) begin
          done      = 1'h1;
          done_data = i_low_addr_data_in;
          d.st      = msd_pkg::ST_IDLE;
        end
      end
      msd_pkg::ST_XADDR: begin
        if (q.ph == `MSD_SLOT_LAST) begin
          d.st = msd_pkg::ST_XDATA;
        end
      end
      msd_pkg::ST_XDATA: begin
        if (q.ph == `MSD_SLOT_LAST) begin
          done      = 1'h1;
          done_data = q.we ? q.rdata : i_low_addr_data_in;
          d.st      = msd_pkg::ST_IDLE;
        end
      end
    endcase
    if (done) begin
      d.rdata     = done_data;
      d.fetch_ack = (d.kind == msd_pkg::KIND_FETCH);
      d.code_ack  = (d.kind == msd_pkg::KIND_CODE);
      d.xmove_ack = (d.kind == msd_pkg::KIND_XMOVE);
      d.int_ack   = (d.kind == msd_pkg::KIND_INT);
    end
    // pins follow the state and phase they belong to
    d.bus_own = (d.st == msd_pkg::ST_FETCH) || (d.st == msd_pkg::ST_XADDR) ||
                (d.st == msd_pkg::ST_XDATA);
    d.ale     = (d.ph <= `MSD_ALE_LAST) && (d.st != msd_pkg::ST_XDATA);
    d.psen_n  = !(d.st == msd_pkg::ST_FETCH && d.ph >= `MSD_STROBE_FIRST &&
                  d.ph <= `MSD_STROBE_LAST);
    d.rd_n    = !(d.st == msd_pkg::ST_XDATA && !d.we && d.ph <= `MSD_STROBE_LAST);
    d.wr_n    = !(d.st == msd_pkg::ST_XDATA && d.we && d.ph <= `MSD_STROBE_LAST);
    d.p0_oe   = ((d.st == msd_pkg::ST_FETCH || d.st == msd_pkg::ST_XADDR) &&
                 d.ph <= `MSD_ALE_LAST) || (d.st == msd_pkg::ST_XDATA && d.we);
    d.p0_out  = (d.st == msd_pkg::ST_XDATA) ? d.wdata : d.addr[7:0];
    if (d.bus_own) begin
      d.p2 = d.addr[15:8];
    end
    if (i_sys_rst) begin
      d           = '0;
      // first slot after release starts at phase 0 with a full two-cycle ale
      d.ph        = `MSD_SLOT_LAST;
      d.fetch_sel = i_external_fetch_select;
      d.psen_n    = `MSD_STROBE_IDLE;
      d.rd_n      = `MSD_STROBE_IDLE;
      d.wr_n      = `MSD_STROBE_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    q <= d;
  end

  assign o_fetch_ack         = q.fetch_ack;
  assign o_code_ack          = q.code_ack;
  assign o_xmove_ack         = q.xmove_ack;
  assign o_int_ack           = q.int_ack;
  assign o_rdata             = q.rdata;
  assign o_rom_en            = q.rom_en;
  assign o_rom_addr          = q.rom_addr;
  assign o_sfr_req           = q.sfr_req;
  assign o_sfr_we            = q.sfr_we;
  assign o_sfr_addr          = q.sfr_addr;
  assign o_sfr_wdata         = q.sfr_wdata;
  assign o_low_addr_data_out = q.p0_out;
  assign o_low_addr_data_oe  = q.p0_oe;
  assign o_high_addr_byte    = q.p2;
  assign o_bus_own           = q.bus_own;
  assign o_ale               = q.ale;
  assign o_prog_store_en_n   = q.psen_n;
  assign o_port3_bit6_pin_n  = q.wr_n;
  assign o_port3_bit7_pin_n  = q.rd_n;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_fetch_slot;
    (o_ale && o_low_addr_data_oe) ##1 o_ale
    ##1 (!o_prog_store_en_n && !o_low_addr_data_oe)[*3]
    ##1 o_prog_store_en_n ##1 (o_fetch_ack || o_code_ack);
  endsequence

  sequence s_addr_slot;
    (o_ale && o_low_addr_data_oe) ##1 o_ale;
  endsequence

  sequence s_read_slot;
    (!o_ale && !o_port3_bit7_pin_n && o_port3_bit6_pin_n)[*5]
    ##1 o_port3_bit7_pin_n ##1 o_xmove_ack;
  endsequence

  sequence s_write_slot;
    (!o_ale && !o_port3_bit6_pin_n && o_low_addr_data_oe)[*5]
    ##1 o_port3_bit6_pin_n ##1 o_xmove_ack;
  endsequence

  rom_fetch_quiet_a: assert property (take && i_fetch_req && fetch_in_rom |->
    ##1 (o_rom_en && !o_bus_own) ##1 (o_fetch_ack && o_prog_store_en_n && !o_bus_own))
    else $error("rom fetch made a bus cycle");
  ext_fetch_a: assert property (q.st == msd_pkg::ST_FETCH && q.ph == 3'h0 |->
    s_fetch_slot) else $error("external fetch slot malformed");
  fetch_select_low_a: assert property (!q.fetch_sel |-> !o_rom_en)
    else $error("rom used with fetch select low");
  secure_block_a: assert property (take && !i_fetch_req && i_code_read_req &&
    code_in_rom && !i_code_read_from_ext && i_security_bit |=>
    o_code_ack && o_rdata == 8'h00 && !o_rom_en) else $error("protected code read out");
  code_redirect_a: assert property (take && !i_fetch_req && i_code_read_req &&
    code_in_rom && i_code_read_from_ext |=> !o_rom_en ##[1:7] o_bus_own)
    else $error("external code read reached rom");
  aux_quiet_a: assert property (take && !i_fetch_req && !i_code_read_req &&
    i_xmove_req && !(i_xmove_use_pointer16 && i_sixteen_bit_pointer > 16'h00ff) |=>
    o_xmove_ack && !o_bus_own && o_port3_bit6_pin_n && o_port3_bit7_pin_n)
    else $error("aux ram access touched bus");
  sfr_route_a: assert property (take && !i_fetch_req && !i_code_read_req &&
    !i_xmove_req && i_int_req && i_int_mode == msd_pkg::MODE_DIRECT &&
    i_int_addr[7] |=> o_sfr_req && o_sfr_addr == $past(i_int_addr) ##1 o_int_ack)
    else $error("direct upper access missed special space");
  ext_read_a: assert property (q.st == msd_pkg::ST_XADDR && q.ph == 3'h0 && !q.we |->
    s_addr_slot ##5 s_read_slot) else $error("external read cycle malformed");
  ext_write_a: assert property (q.st == msd_pkg::ST_XADDR && q.ph == 3'h0 && q.we |->
    s_addr_slot ##5 s_write_slot) else $error("external write cycle malformed");
  ale_period_a: assert property ($rose(o_ale) && q.st != msd_pkg::ST_XADDR |->
    ##1 o_ale ##1 (!o_ale)[*4] ##1 o_ale) else $error("ale period wrong");
  ale_skip_a: assert property ($rose(o_ale) && q.st == msd_pkg::ST_XADDR |->
    ##6 (!o_ale)[*6]) else $error("ale pulse not skipped");
  high_addr_a: assert property (o_bus_own && o_ale |->
    o_high_addr_byte == q.addr[15:8]) else $error("high address byte wrong");
endmodule : msd_decoder

`default_nettype wire

// ### verification/msd_ext_mem.sv
// external program and data memory seen through the multiplexed port 0/2 bus
// assumes the bench resolves the port 0 pin level from all drivers
`default_nettype none

module msd_ext_mem (
  input  wire logic       i_clk,
  input  wire logic       i_ale,
  input  wire logic       i_oe,
  input  wire logic       i_psen_n,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic [7:0] i_pin,
  input  wire logic [7:0] i_hi,
  output logic            o_drv,
  output logic      [7:0] o_dq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] addr_q;
  logic [7:0]  wr_q;
  logic        held_q;
  //////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    if (i_ale && i_oe) addr_q <= {i_hi, i_pin};
    if (!i_wr_n) wr_q <= i_pin;
    held_q <= !i_psen_n || !i_rd_n;
  end
  // data held one cycle past the strobe
  assign o_drv = !i_psen_n || !i_rd_n || held_q;
  assign o_dq  = addr_q[7:0] ^ addr_q[15:8] ^ 8'ha5;
endmodule : msd_ext_mem

`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the memory space decoder with an external memory model
// assumes 50 ns clock, pull-ups on port 0, rom and special registers modelled inline
`default_nettype none

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %0t got %h want %h", $time, g, e); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, ea = 1'b1, sec = 1'b0, cext = 1'b0, we = 1'b0;
  logic p16 = 1'b0, fr = 1'b0, cr = 1'b0, xr = 1'b0, ir = 1'b0, ptr = 1'b0, bitv = 1'b0;
  logic [15:0] a = 16'h0000;
  logic [7:0]  wd = 8'h00, sp = 8'h00, r, rd, pin, lo_out, hi, mdq, sfr_a, sfr_wd;
  logic [7:0]  sfr_w = 8'h00;
  logic [2:0]  rsel = 3'h0;
  logic [1:0]  bank = 2'h0;
  logic [13:0] rom_a;
  logic fack, cack, xack, iack, rom_en, sreq, swe, oe, own, ale, psen_n, wr_n, rd_n, mdrv;
  msd_pkg::msd_int_mode_t mode = msd_pkg::MODE_DIRECT;
  int bad_count = 0, checked = 0, own_cnt = 0, sfr_cnt = 0, stb_cnt = 0, n0;
  always #25 clk = ~clk;
  assign pin = oe ? lo_out : (mdrv ? mdq : 8'hff);
  always @(posedge clk) begin
    own_cnt += int'(own === 1'b1);
    sfr_cnt += int'(sreq === 1'b1);
    stb_cnt += int'(rd_n === 1'b0 || wr_n === 1'b0);
    if (sreq === 1'b1 && swe === 1'b1) begin
      sfr_w = sfr_wd;
    end
  end
  msd_decoder i_dut (.i_clk(clk), .i_sys_rst(rst), .i_external_fetch_select(ea),
    .i_security_bit(sec), .i_fetch_req(fr), .i_fetch_addr(a), .o_fetch_ack(fack),
    .i_code_read_req(cr), .i_code_read_addr(a), .i_code_read_from_ext(cext),
    .o_code_ack(cack), .i_xmove_req(xr), .i_xmove_we(we), .i_xmove_use_pointer16(p16),
    .i_sixteen_bit_pointer(a), .o_xmove_ack(xack), .i_int_req(ir), .i_int_we(we),
    .i_int_mode(mode), .i_int_addr(a[7:0]), .i_reg_sel(rsel), .i_ptr_sel(ptr),
    .i_bank_sel(bank), .i_stack_ptr(sp), .i_bit_value(bitv), .o_int_ack(iack),
    .i_wdata(wd), .o_rdata(rd), .o_rom_en(rom_en), .o_rom_addr(rom_a),
    .i_rom_data(rom_a[7:0] ^ 8'h3c), .o_sfr_req(sreq), .o_sfr_we(swe),
    .o_sfr_addr(sfr_a), .o_sfr_wdata(sfr_wd), .i_sfr_rdata(sfr_a ^ 8'h0f),
    .o_low_addr_data_out(lo_out), .o_low_addr_data_oe(oe), .i_low_addr_data_in(pin),
    .o_high_addr_byte(hi), .o_bus_own(own), .o_ale(ale), .o_prog_store_en_n(psen_n),
    .o_port3_bit6_pin_n(wr_n), .o_port3_bit7_pin_n(rd_n));
  msd_ext_mem i_mem (.i_clk(clk), .i_ale(ale), .i_oe(oe), .i_psen_n(psen_n),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_pin(pin), .i_hi(hi), .o_drv(mdrv), .o_dq(mdq));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] ext(input logic [15:0] ad);
    return ad[7:0] ^ ad[15:8] ^ 8'ha5;
  endfunction : ext
  task print_verdict;
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // k: 0 fetch, 1 code read, 2 external move, 3 internal access
  task op(input int k, input logic [15:0] ad, input logic w);
    int n;
    a = ad;
    we = w;
    {fr, cr, xr, ir} = {k == 0, k == 1, k == 2, k == 3};
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      #1;
      if ((fack | cack | xack | iack) === 1'b1) break;
    end
    if (n == 40) begin
      bad_count++;
      print_verdict();
    end
    r = rd;
    {fr, cr, xr, ir} = 4'h0;
    @(posedge clk);
    #1;
  endtask : op
  task do_reset(input logic lvl);
    rst = 1'b1;
    ea = lvl;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
  endtask : do_reset
  //////////////////////////////////////////////////////////////////////////
  task t_fetch;
    n0 = own_cnt;
    op(0, 16'h1234, 1'b0); `CHK(r, 8'h34 ^ 8'h3c);
    op(0, 16'h3fff, 1'b0); `CHK(r, 8'hff ^ 8'h3c);
    `CHK(own_cnt, n0);
    op(0, 16'h4000, 1'b0); `CHK(r, ext(16'h4000));
    `CHK(hi, 8'h40);
  endtask : t_fetch
  task t_code;
    sec = 1'b1;
    op(1, 16'h0100, 1'b0); `CHK(r, 8'h00);
    sec = 1'b0;
    op(1, 16'h0100, 1'b0); `CHK(r, 8'h00 ^ 8'h3c);
    cext = 1'b1;
    op(1, 16'h0100, 1'b0); `CHK(r, ext(16'h0100));
    cext = 1'b0;
  endtask : t_code
  task t_int;
    mode = msd_pkg::MODE_REG;
    {bank, rsel, wd} = {2'h2, 3'h3, 8'h5a};
    op(3, 16'h0000, 1'b1);
    mode = msd_pkg::MODE_DIRECT;
    op(3, 16'h0013, 1'b0); `CHK(r, 8'h5a);
    // bank 2 pointers: zero -> c0, one -> f0
    mode = msd_pkg::MODE_REG;
    {rsel, wd} = {3'h0, 8'hc0};
    op(3, 16'h0000, 1'b1);
    {rsel, wd} = {3'h1, 8'hf0};
    op(3, 16'h0000, 1'b1);
    mode = msd_pkg::MODE_INDIRECT;
    wd = 8'ha7;
    op(3, 16'h00c0, 1'b1);
    n0 = sfr_cnt;
    mode = msd_pkg::MODE_DIRECT;
    op(3, 16'h00c0, 1'b0); `CHK(r, 8'hcf);
    `CHK(sfr_cnt, n0 + 1);
    mode = msd_pkg::MODE_INDIRECT;
    op(3, 16'h00c0, 1'b0); `CHK(r, 8'ha7);
    mode = msd_pkg::MODE_BIT;
    bitv = 1'b1;
    op(3, 16'h000a, 1'b1);
    mode = msd_pkg::MODE_DIRECT;
    op(3, 16'h0021, 1'b0); `CHK(r, 8'h04);
    // special register bit clear: byte c0 reads cf, bit 3 cleared gives c7
    mode = msd_pkg::MODE_BIT;
    bitv = 1'b0;
    n0 = sfr_cnt;
    op(3, 16'h00c3, 1'b1); `CHK(r, 8'h01);
    `CHK(sfr_w, 8'hc7);
    `CHK(sfr_cnt, n0 + 2);
    mode = msd_pkg::MODE_STACK;
    {sp, wd} = {8'hf0, 8'h3c};
    op(3, 16'h0000, 1'b1);
    mode = msd_pkg::MODE_INDIRECT;
    ptr = 1'b1;
    op(3, 16'h00f0, 1'b0); `CHK(r, 8'h3c);
    ptr = 1'b0;
  endtask : t_int
  task t_xmove;
    n0 = own_cnt;
    {p16, wd} = {1'b1, 8'h66};
    op(2, 16'h00ff, 1'b1);
    op(2, 16'h00ff, 1'b0); `CHK(r, 8'h66);
    {p16, bank, ptr, wd} = {1'b0, 2'h1, 1'b0, 8'h11};
    op(2, 16'hff00, 1'b1);
    p16 = 1'b1;
    op(2, 16'h0000, 1'b0); `CHK(r, 8'h11);
    `CHK(own_cnt, n0);
    n0 = stb_cnt;
    op(2, 16'h1234, 1'b0); `CHK(r, ext(16'h1234));
    `CHK(stb_cnt, n0 + 5);
    wd = 8'h99;
    op(2, 16'h1235, 1'b1); `CHK(i_mem.wr_q, 8'h99);
    `CHK(stb_cnt, n0 + 10);
  endtask : t_xmove
  task t_ale;
    int k;
    n0 = 0;
    for (k = 0; k < 60; k++) begin
      @(posedge clk);
      #1;
      n0 += int'(ale === 1'b1);
    end
    `CHK(n0, 20);
  endtask : t_ale
  task t_ea_low;
    do_reset(1'b0);
    ea = 1'b1;
    op(0, 16'h0010, 1'b0); `CHK(r, ext(16'h0010));
  endtask : t_ea_low
  initial begin
    do_reset(1'b1);
    t_fetch();
    t_code();
    t_int();
    t_xmove();
    t_ale();
    t_ea_low();
    print_verdict();
  end
endmodule : tb_top

`default_nettype wire
